// ---- serial_ctrl_map.svh ----
// Register map, field positions and reset values of the serial controller
`ifndef SERIAL_CTRL_MAP_SVH
`define SERIAL_CTRL_MAP_SVH
`define ADDR_CONFIG 8'h9a
`define ADDR_DATA 8'h9b
`define ADDR_DIVIDER 8'h9d
`define ADDR_CONTROL 8'hf8
`define RST_CONFIG 8'h07
`define RST_DATA 8'h00
`define RST_DIVIDER 8'h00
`define RST_CONTROL 8'h00
`define CFG_PHASE 7
`define CFG_POLARITY 6
`define CTL_DONE 7
`define CTL_WRITE_COLLISION_FLAG 6
`define CTL_MODE_FAULT_FLAG 5
`define CTL_OVRN 4
`define CTL_BUSY 3
`define CTL_SLAVE_SELECTED_FLAG 2
`define CTL_MASTER_ENABLE 1
`define CTL_EN 0
`endif

// ---- serial_ctrl_pkg.sv ----
// Types shared by the serial controller
`default_nettype none
package serial_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_TRAIL = 2'b10
  } master_state_t;
  typedef struct packed {
    logic phase;
    logic polarity;
    logic [2:0] frame_size;
  } cfg_t;
  typedef struct packed {
    logic done;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic ovrn;
    logic master_enable;
    logic block_enable;
  } ctl_t;
endpackage : serial_ctrl_pkg
`default_nettype wire

// ---- serial_ctrl.sv ----
// Serial peripheral controller, master or slave, special function register port
`include "serial_ctrl_map.svh"
`default_nettype none
module serial_ctrl
  import serial_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Serial pins
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_slave_select_n,
  // Interrupt
  output logic o_irq
);

  // Pin synchronisers
  logic [3:0] meta_q, sync_q;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= 4'hf;
      sync_q <= 4'hf;
    end else begin
      meta_q <= {i_sck, i_mosi, i_miso, i_slave_select_n};
      sync_q <= meta_q;
    end
  end
  logic sck_s, mosi_s, miso_s, nss_s;
  assign {sck_s, mosi_s, miso_s, nss_s} = sync_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  // Register state
  cfg_t cfg_q, cfg_d;
  ctl_t ctl_q, ctl_d;
  logic [7:0] div_q, div_d;
  logic [7:0] rxbuf_q, rxbuf_d;
  logic rx_full_q, rx_full_d;
  logic [7:0] shift_q, shift_d;
  logic [2:0] bits_q, bits_d;
  logic [2:0] bitcnt_q, bitcnt_d;
  master_state_t mst_q, mst_d;
  logic [7:0] tick_q, tick_d;
  logic sck_q, sck_d, mosi_q, mosi_d, miso_q, miso_d;
  logic nss_prev_q, sck_prev_q;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic sck_oe_q, mosi_oe_q, miso_oe_q;
  // Two-entry receive buffer between shifter and data register
  logic [7:0] fifo_q [2];
  logic [7:0] fifo_d [2];
  logic [1:0] fcnt_q, fcnt_d;

  logic busy, master, slave_act, wr_data, rd_data, lead_edge, trail_edge;
  logic in_valid, in_ready, slave_end;
  logic [7:0] in_word;
  assign master = ctl_q.block_enable & ctl_q.master_enable;
  assign slave_act = ctl_q.block_enable & ~ctl_q.master_enable & ~nss_s;
  assign busy = (mst_q != ST_IDLE);
  assign wr_data = i_wr & hit(i_addr, `ADDR_DATA);
  assign rd_data = i_rd & hit(i_addr, `ADDR_DATA);
  // slave edges relative to idle level
  assign lead_edge = slave_act & (sck_s != sck_prev_q) & (sck_s != cfg_q.polarity);
  assign trail_edge = slave_act & (sck_s != sck_prev_q) & (sck_s == cfg_q.polarity);
  assign slave_end = ctl_q.block_enable & ~ctl_q.master_enable & nss_s & ~nss_prev_q;
  assign in_ready = (fcnt_q != 2'd2);

  always_comb begin
    cfg_d = cfg_q;
    ctl_d = ctl_q;
    div_d = div_q;
    shift_d = shift_q;
    bits_d = bits_q;
    bitcnt_d = bitcnt_q;
    mst_d = mst_q;
    tick_d = tick_q;
    sck_d = sck_q;
    mosi_d = mosi_q;
    miso_d = miso_q;
    in_valid = 1'b0;
    in_word = shift_q;
    if (i_wr && hit(i_addr, `ADDR_CONFIG)) begin
      cfg_d.phase = i_wdata[`CFG_PHASE];
      cfg_d.polarity = i_wdata[`CFG_POLARITY];
      cfg_d.frame_size = i_wdata[2:0];
    end
    if (i_wr && hit(i_addr, `ADDR_DIVIDER)) begin
      div_d = i_wdata;
    end
    if (i_wr && hit(i_addr, `ADDR_CONTROL)) begin
      ctl_d.done = ctl_q.done & i_wdata[`CTL_DONE];
      ctl_d.write_collision_flag = ctl_q.write_collision_flag & i_wdata[`CTL_WRITE_COLLISION_FLAG];
      ctl_d.mode_fault_flag = ctl_q.mode_fault_flag & i_wdata[`CTL_MODE_FAULT_FLAG];
      ctl_d.ovrn = ctl_q.ovrn & i_wdata[`CTL_OVRN];
      ctl_d.master_enable = i_wdata[`CTL_MASTER_ENABLE];
      ctl_d.block_enable = i_wdata[`CTL_EN];
    end
    unique case (mst_q)
      ST_IDLE: begin
        sck_d = cfg_q.polarity;
        if (master && wr_data) begin
          shift_d = i_wdata;
          bits_d = cfg_q.frame_size;
          bitcnt_d = 3'd0;
          tick_d = div_q;
          mst_d = ST_LEAD;
          mosi_d = i_wdata[7];
        end
      end
      ST_LEAD, ST_TRAIL: begin
        // half period of divider plus one
        if (tick_q != 8'h00) begin
          tick_d = tick_q - 8'd1;
        end else begin
          tick_d = div_q;
          sck_d = ~sck_q;
          if (mst_q == ST_LEAD) begin
            mst_d = ST_TRAIL;
            if (!cfg_q.phase) begin
              shift_d = {shift_q[6:0], miso_s};
            end else begin
              mosi_d = shift_q[7];
            end
          end else begin
            if (cfg_q.phase) begin
              shift_d = {shift_q[6:0], miso_s};
            end
            bitcnt_d = bitcnt_q + 3'd1;
            if (bits_q == 3'd0) begin
              mst_d = ST_IDLE;
              in_valid = 1'b1;
              in_word = shift_d;
              ctl_d.done = 1'b1;
              bitcnt_d = bitcnt_q;
            end else begin
              bits_d = bits_q - 3'd1;
              mst_d = ST_LEAD;
              if (!cfg_q.phase) begin
                mosi_d = shift_d[7];
              end
            end
          end
        end
      end
      default: begin
        mst_d = ST_IDLE;
      end
    endcase
    // Leaving master role aborts a word, so the clock cannot keep toggling
    if (!master) begin
      mst_d = ST_IDLE;
      sck_d = cfg_q.polarity;
    end
    // slave ignores divider and frame size
    if (~ctl_q.master_enable) begin
      if (wr_data && !slave_act) begin
        shift_d = i_wdata;
        miso_d = i_wdata[7];
      end
      if (slave_act && nss_prev_q && !cfg_q.phase) begin
        miso_d = shift_q[7];
      end
      if ((lead_edge && !cfg_q.phase) || (trail_edge && cfg_q.phase)) begin
        shift_d = {shift_q[6:0], mosi_s};
        bitcnt_d = bitcnt_q + 3'd1;
      end
      if ((trail_edge && !cfg_q.phase) || (lead_edge && cfg_q.phase)) begin
        miso_d = shift_q[7];
      end
      if (slave_end) begin
        in_valid = 1'b1;
        ctl_d.done = 1'b1;
        bitcnt_d = 3'd0;
      end
    end
    if (wr_data && (busy || slave_act)) begin
      ctl_d.write_collision_flag = 1'b1;
    end
    if (in_valid && (rx_full_q || !in_ready)) begin
      ctl_d.ovrn = 1'b1;
    end
    if (master && !nss_s) begin
      ctl_d.mode_fault_flag = 1'b1;
      ctl_d.master_enable = 1'b0;
      ctl_d.block_enable = 1'b0;
      mst_d = ST_IDLE;
    end
  end

  // Receive buffer path; overrun word never displaces unread data
  always_comb begin
    fifo_d = fifo_q;
    fcnt_d = fcnt_q;
    rxbuf_d = rxbuf_q;
    rx_full_d = rx_full_q;
    if (rd_data) begin
      rx_full_d = 1'b0;
    end
    if (fcnt_q != 2'd0 && (!rx_full_q || rd_data)) begin
      rxbuf_d = fifo_q[0];
      rx_full_d = 1'b1;
      fifo_d[0] = fifo_q[1];
      fcnt_d = fcnt_q - 2'd1;
    end
    if (in_valid && in_ready && !rx_full_q) begin
      fifo_d[fcnt_d[0]] = in_word;
      fcnt_d = fcnt_d + 2'd1;
    end
  end

  // Read mux; data reads the buffer
  always_comb begin
    rdata_d = 8'h00;
    if (hit(i_addr, `ADDR_CONFIG)) begin
      rdata_d = {cfg_q.phase, cfg_q.polarity, bitcnt_q, cfg_q.frame_size};
    end else if (hit(i_addr, `ADDR_DATA)) begin
      rdata_d = rxbuf_q;
    end else if (hit(i_addr, `ADDR_DIVIDER)) begin
      rdata_d = div_q;
    end else if (hit(i_addr, `ADDR_CONTROL)) begin
      rdata_d = {ctl_q.done, ctl_q.write_collision_flag, ctl_q.mode_fault_flag, ctl_q.ovrn, busy, ~nss_s,
                 ctl_q.master_enable, ctl_q.block_enable};
    end
    irq_d = ctl_d.done | ctl_d.write_collision_flag | ctl_d.mode_fault_flag | ctl_d.ovrn;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_q <= cfg_t'(5'b00111);
      ctl_q <= '0;
      div_q <= `RST_DIVIDER;
      rxbuf_q <= `RST_DATA;
      rx_full_q <= 1'b0;
      shift_q <= 8'h00;
      bits_q <= 3'd0;
      bitcnt_q <= 3'd0;
      mst_q <= ST_IDLE;
      tick_q <= 8'h00;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
      miso_q <= 1'b0;
      nss_prev_q <= 1'b1;
      // Matches synchroniser reset, so no false edge
      sck_prev_q <= 1'b1;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      sck_oe_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_oe_q <= 1'b0;
      fifo_q[0] <= 8'h00;
      fifo_q[1] <= 8'h00;
      fcnt_q <= 2'd0;
    end else begin
      cfg_q <= cfg_d;
      ctl_q <= ctl_d;
      div_q <= div_d;
      rxbuf_q <= rxbuf_d;
      rx_full_q <= rx_full_d;
      shift_q <= shift_d;
      bits_q <= bits_d;
      bitcnt_q <= bitcnt_d;
      mst_q <= mst_d;
      tick_q <= tick_d;
      sck_q <= sck_d;
      mosi_q <= mosi_d;
      miso_q <= miso_d;
      nss_prev_q <= nss_s;
      sck_prev_q <= sck_s;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      sck_oe_q <= ctl_d.block_enable & ctl_d.master_enable;
      mosi_oe_q <= ctl_d.block_enable & ctl_d.master_enable;
      miso_oe_q <= ctl_d.block_enable & ~ctl_d.master_enable & ~nss_s;
      fifo_q <= fifo_d;
      fcnt_q <= fcnt_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_sck = sck_q;
  assign o_sck_oe = sck_oe_q;
  assign o_mosi = mosi_q;
  assign o_mosi_oe = mosi_oe_q;
  assign o_miso = miso_q;
  assign o_miso_oe = miso_oe_q;
  assign o_irq = irq_q;

endmodule : serial_ctrl
`default_nettype wire

// ---- serial_ctrl_props.sv ----
// Port-level checker of the serial controller
`include "serial_ctrl_map.svh"
`default_nettype none
module serial_ctrl_props (
  // Clock, reset and register port
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  // Pins and interrupt
  input wire logic o_sck,
  input wire logic o_sck_oe,
  input wire logic o_mosi_oe,
  input wire logic o_miso_oe,
  input wire logic i_slave_select_n,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  logic [7:0] div_q;
  logic [9:0] gap_q;
  logic sck_q;
  logic edge_w;
  logic [9:0] half_w;
  assign edge_w = o_sck != sck_q;
  assign half_w = {2'b00, div_q} + 10'h001;
  // Divider mirror; gap saturates so idle spells never wrap
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      div_q <= 8'h00;
      gap_q <= 10'h000;
      sck_q <= 1'b0;
    end else begin
      sck_q <= o_sck;
      if (i_wr && i_addr == `ADDR_DIVIDER) div_q <= i_wdata;
      if (edge_w) gap_q <= 10'h001;
      else if (gap_q != 10'h3ff) gap_q <= gap_q + 10'h001;
    end
  end
  sequence sel_low_s;
    (!i_slave_select_n) [*6];
  endsequence
  sequence sel_steady_s;
    $stable(i_slave_select_n) [*5];
  endsequence
  irq_flags_a: assert property ($past(i_addr) == `ADDR_CONTROL |-> $past(o_irq) == |o_rdata[7:4])
    else $error("interrupt disagrees with flags");
  slave_selected_flag_flag_a: assert property (sel_steady_s ##0 $past(i_addr) == `ADDR_CONTROL
    |-> o_rdata[`CTL_SLAVE_SELECTED_FLAG] == !i_slave_select_n) else $error("selected flag wrong");
  sck_half_a: assert property (edge_w && gap_q < (half_w << 1) |-> gap_q == half_w)
    else $error("serial clock half period wrong");
  mode_fault_flag_irq_a: assert property (o_sck_oe && !i_slave_select_n |-> ##[1:6] o_irq)
    else $error("mode fault raised no interrupt");
  mode_fault_flag_off_a: assert property (sel_low_s |-> !o_sck_oe && !o_mosi_oe)
    else $error("master still driving after mode fault");
  miso_hiz_a: assert property (i_slave_select_n [*5] |-> !o_miso_oe)
    else $error("unselected slave drives its output");
  role_excl_a: assert property (o_miso_oe |-> !o_sck_oe)
    else $error("master and slave outputs both driven");
  mosi_oe_a: assert property (o_mosi_oe == o_sck_oe)
    else $error("data and clock enables differ");
endmodule : serial_ctrl_props
bind serial_ctrl serial_ctrl_props serial_ctrl_props_i (.i_clk_sys, .i_nrst, .i_addr, .i_wr, .i_wdata,
  .o_rdata, .o_sck, .o_sck_oe, .o_mosi_oe, .o_miso_oe, .i_slave_select_n, .o_irq);
`default_nettype wire

// ---- serial_slave_model.sv ----
// Behavioural serial slave answering the controller in master role
`default_nettype none
module serial_slave_model (
  // Pins seen by the slave
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_select_n,
  // Mode and word to send
  input wire logic i_polarity,
  input wire logic i_phase,
  input wire logic [7:0] i_tx,
  // Reply line and captured word
  output logic o_miso,
  output logic [7:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  initial o_miso = 1'b0;
  // phase 0 shows the top bit before the first edge
  always @(negedge i_select_n) begin
    o_rx = 8'h00;
    sh = i_phase ? i_tx : {i_tx[6:0], 1'b0};
    if (!i_phase) o_miso = i_tx[7];
  end
  // sample on one edge, shift on the other
  always @(i_sck) begin
    if (!i_select_n && ((i_sck != i_polarity) != i_phase)) o_rx = {o_rx[6:0], i_mosi};
    else if (!i_select_n) begin
      o_miso = sh[7];
      sh = {sh[6:0], 1'b0};
    end
  end
  // released line must not keep its last level
  always @(posedge i_select_n) o_miso = ~o_miso;
endmodule : serial_slave_model
`default_nettype wire

// ---- testbench.sv ----
// Register-level bench of the serial controller
`include "serial_ctrl_map.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys, i_nrst, i_wr, i_rd, ssn, sel_n, pol, pha, sck, mosi, miso, s_miso;
  logic o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, o_irq;
  logic [7:0] i_addr, i_wdata, o_rdata, v, rx;
  logic [7:0] ra [5] = '{`ADDR_CONFIG, `ADDR_DATA, `ADDR_DIVIDER, `ADDR_CONTROL, 8'h9c};
  logic [7:0] rv [5] = '{`RST_CONFIG, `RST_DATA, `RST_DIVIDER, `RST_CONTROL, 8'h00};
  int errors = 0;
  int total_checks = 0;
  assign sck = o_sck_oe ? o_sck : 1'b0;
  assign mosi = o_mosi_oe ? o_mosi : 1'b1;
  assign miso = o_miso_oe ? o_miso : s_miso;
  serial_ctrl serial_ctrl_i (.i_clk_sys, .i_nrst, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .i_sck(sck),
    .o_sck, .o_sck_oe, .i_mosi(mosi), .o_mosi, .o_mosi_oe, .i_miso(miso), .o_miso, .o_miso_oe,
    .i_slave_select_n(ssn), .o_irq);
  serial_slave_model serial_slave_model_i (.i_sck(sck), .i_mosi(mosi), .i_select_n(sel_n),
    .i_polarity(pol), .i_phase(pha), .i_tx(8'h3c), .o_miso(s_miso), .o_rx(rx));
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic give_verdict;
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  // Word with a colliding write, then a bounded wait for idle
  task automatic xfer(input logic [7:0] d);
    int k;
    @(posedge i_clk_sys);
    sel_n <= 1'b0;
    wr(`ADDR_DATA, d);
    rd(`ADDR_CONTROL);
    chk(v & 8'h08, 8'h08);
    wr(`ADDR_DATA, 8'hff);
    k = 0;
    do begin
      rd(`ADDR_CONTROL);
      k++;
    end while (v[`CTL_BUSY] && k < 400);
    if (k == 400) begin
      errors++;
      give_verdict();
    end
    @(posedge i_clk_sys);
    sel_n <= 1'b1;
  endtask : xfer
  initial begin
    {i_nrst, i_wr, i_rd, ssn, sel_n, pol, pha} = 7'b0001100;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    repeat (12) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(v, rv[i]);
    end
    for (int m = 0; m < 4; m++) begin
      wr(`ADDR_CONTROL, 8'h00);
      pha <= m[1];
      pol <= m[0];
      wr(`ADDR_CONFIG, {m[1:0], 6'h07});
      wr(`ADDR_DIVIDER, 8'h03);
      rd(`ADDR_CONTROL);
      chk(v & 8'h04, 8'h00);
      wr(`ADDR_CONTROL, 8'h03);
      xfer(8'ha5);
      rd(`ADDR_CONTROL);
      chk(v, 8'hc3);
      chk({7'h00, o_irq}, 8'h01);
      chk({7'h00, o_sck}, {7'h00, m[0]});
      rd(`ADDR_DATA);
      chk(v, 8'h3c);
      chk(rx, 8'ha5);
      rd(`ADDR_CONFIG);
      chk(v, {m[1:0], 6'h3f});
    end
    // Short frame, buffer left unread twice
    wr(`ADDR_CONFIG, 8'hc3);
    xfer(8'ha5);
    xfer(8'ha5);
    chk(rx, 8'h0a);
    rd(`ADDR_CONFIG);
    chk(v, 8'hdb);
    rd(`ADDR_CONTROL);
    chk(v, 8'hd3);
    rd(`ADDR_DATA);
    chk(v, 8'h53);
    wr(`ADDR_CONTROL, 8'h03);
    rd(`ADDR_CONTROL);
    chk(v, 8'h03);
    chk({7'h00, o_irq}, 8'h00);
    @(posedge i_clk_sys);
    ssn <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    rd(`ADDR_CONTROL);
    chk(v, 8'h24);
    chk({7'h00, o_irq}, 8'h01);
    wr(`ADDR_CONTROL, 8'h01);
    repeat (4) @(posedge i_clk_sys);
    chk({7'h00, o_miso_oe}, 8'h01);
    ssn <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    rd(`ADDR_CONTROL);
    chk(v, 8'h81);
    chk({7'h00, o_miso_oe}, 8'h00);
    wr(`ADDR_DATA, 8'h96);
    @(posedge i_clk_sys);
    ssn <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    chk({6'h00, o_miso_oe, o_miso}, 8'h03);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
